// *** core/bpe_port.sv ***
// eight-bit bidirectional port with apb register access
//
// Summary of operation
// - direction one drives latch level push-pull
// - pull-up on: input, latch one, enabled
// - otherwise pull-up off, input high-impedance
// - reset tri-states all pins without clock
// - pin read gives synced levels, latch stored
// - pin location read-only; others read/write
// - decode latch, direction, pin-level locations
// - bit set/clear touches only addressed bits
// - all eight pins behave identically
// - pin inputs pass clocked synchronisers
// - power-down disconnects digital input path
// - every pin has own pull-up control
`timescale 1ns/1ps
module bpe_port
    import bpe_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // power management
    input wire logic power_down,
    // package pins
    input wire logic [PORT_W-1:0] port_pin_i,
    output logic [PORT_W-1:0] port_pin_o,
    output logic [PORT_W-1:0] port_pin_oe,
    output logic [PORT_W-1:0] port_pullup_en,
    output logic port_in_buf_en
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [PORT_W-1:0] latch_q;   // output latch
    logic [PORT_W-1:0] latch_d;
    logic [PORT_W-1:0] dir_q;     // direction bits
    logic [PORT_W-1:0] dir_d;
    logic pu_dis_q;               // global pull-up disable
    logic pu_dis_d;
    logic [PORT_W-1:0] oe_q;      // registered output enables
    logic [PORT_W-1:0] out_q;     // registered pin levels
    logic [PORT_W-1:0] pu_q;      // registered pull-ups
    logic in_en_q;                // input buffer enable
    logic [DATA_W-1:0] prdata_q;  // captured read data
    logic pready_q;               // access-phase answer
    logic pslverr_q;              // unmapped address flag

    // pin control bundle shared by drive and sampler
    bpe_pin_if pif ();

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    // setup phase: select without enable
    wire setup = psel & ~penable;
    // the one edge at which a transfer completes
    wire done = psel & penable & pready_q;
    wire wr_done = done & pwrite;
    // address hits
    wire hit_pin = (paddr == ADDR_PIN_LEVEL);
    wire hit_dir = (paddr == ADDR_DIRECTION);
    wire hit_latch = (paddr == ADDR_OUT_LATCH);
    wire hit_ctrl = (paddr == ADDR_SPEC_CTRL);
    wire hit_lset = (paddr == ADDR_LATCH_SET);
    wire hit_lclr = (paddr == ADDR_LATCH_CLR);
    wire hit_dset = (paddr == ADDR_DIR_SET);
    wire hit_dclr = (paddr == ADDR_DIR_CLR);
    // any mapped location; everything else answers with an error
    wire hit_any = hit_pin | hit_dir | hit_latch | hit_ctrl |
                   hit_lset | hit_lclr | hit_dset | hit_dclr;
    // low byte of the write data
    wire [PORT_W-1:0] wbyte = pwdata[PORT_W-1:0];

    // ------------------------------------------------------------
    // register next values
    // ------------------------------------------------------------
    // set and clear aliases touch only the bits written as one
    assign latch_d = (wr_done & hit_latch) ? wbyte :
                     (wr_done & hit_lset) ? (latch_q | wbyte) :
                     (wr_done & hit_lclr) ? (latch_q & ~wbyte) :
                     latch_q;
    assign dir_d = (wr_done & hit_dir) ? wbyte :
                   (wr_done & hit_dset) ? (dir_q | wbyte) :
                   (wr_done & hit_dclr) ? (dir_q & ~wbyte) :
                   dir_q;
    // the control location holds only the global pull-up disable
    assign pu_dis_d = (wr_done & hit_ctrl) ? pwdata[PU_DIS_BIT] : pu_dis_q;
    // a write to the pin-level location stores nothing

    // ------------------------------------------------------------
    // read mux, sampled in the setup cycle
    // ------------------------------------------------------------
    wire [DATA_W-1:0] rd_pin = {{(DATA_W-PORT_W){1'b0}}, pif.sampled};
    wire [DATA_W-1:0] rd_latch = {{(DATA_W-PORT_W){1'b0}}, latch_q};
    wire [DATA_W-1:0] rd_dir = {{(DATA_W-PORT_W){1'b0}}, dir_q};
    wire [DATA_W-1:0] rd_ctrl = RDATA_ZERO | (DATA_W'(pu_dis_q) << PU_DIS_BIT);
    // set/clear aliases read back the register they modify
    wire [DATA_W-1:0] rd_mux = hit_pin ? rd_pin :
                               (hit_latch | hit_lset | hit_lclr) ? rd_latch :
                               (hit_dir | hit_dset | hit_dclr) ? rd_dir :
                               hit_ctrl ? rd_ctrl : RDATA_ZERO;

    // ------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------
    assign pif.latch = latch_q;
    assign pif.dir = dir_q;
    assign pif.pu_dis = pu_dis_q;
    assign pif.sleep = power_down;
    assign pif.raw = port_pin_i;

    // per-pin drive and pull-up decode
    bpe_pin_drive u_drive (
        .pif (pif.drv)
    );

    // synchronisers in front of every read of the pins
    bpe_pin_sync u_sync (
        .clk_sys (clk_sys),
        .rst_n (rst_n),
        .pif (pif.smp)
    );

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // every pin an input with its latch low
            latch_q <= RST_LATCH;
            dir_q <= RST_DIRECTION;
            pu_dis_q <= RST_PU_DIS;
        end else begin
            // next values come from the decode above
            latch_q <= latch_d;
            dir_q <= dir_d;
            pu_dis_q <= pu_dis_d;
        end
    end

    // ------------------------------------------------------------
    // pin output registers
    // ------------------------------------------------------------
    // one cycle from register to pin keeps pins glitch free
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // pins float, no pull-up, input buffer off
            oe_q <= '0;
            out_q <= '0;
            pu_q <= '0;
            in_en_q <= 1'b0;
        end else begin
            // copy the per-pin decode of the drive slices
            oe_q <= pif.oe_d;
            out_q <= pif.out_d;
            pu_q <= pif.pu_d;
            in_en_q <= ~power_down;
        end
    end

    // ------------------------------------------------------------
    // apb answer, zero wait states
    // ------------------------------------------------------------
    // data captured in setup, so pready rises in the access cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prdata_q <= RDATA_ZERO;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            // answer in the cycle right after every setup
            pready_q <= setup;
            if (setup) begin
                // read data and decode result taken once per transfer
                prdata_q <= pwrite ? RDATA_ZERO : rd_mux;
                pslverr_q <= ~hit_any;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // bus answer straight from its flip-flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    // drive level needs no gating, the enable decides whether it reaches the pad
    assign port_pin_o = out_q;
    // reset gates the drivers directly, so pins float with no clock
    assign port_pin_oe = oe_q & {PORT_W{rst_n}};
    assign port_pullup_en = pu_q & {PORT_W{rst_n}};
    // input buffer enable only matters with a clock, so it stays registered
    assign port_in_buf_en = in_en_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // enable follows direction one cycle later
    chk_drive_dir: assert property (
        $past(rst_n) |-> (oe_q == $past(dir_q)))
        else $error("output enable does not follow direction");
    // pin level follows the latch
    chk_drive_level: assert property (
        $past(rst_n) |-> (out_q == $past(latch_q)))
        else $error("driven level does not follow latch");
    // pull-up exactly for inputs with latch one and no disable
    chk_pullup_cond: assert property (
        $past(rst_n) |-> (pu_q == ($past(~dir_q & latch_q) & {PORT_W{~$past(pu_dis_q)}})))
        else $error("pull-up enable wrong");
    // never a pull-up on a driven pin
    chk_pullup_off: assert property (
        (pu_q & oe_q) == '0)
        else $error("pull-up on an output pin");
    // reset floats every pin in the same cycle
    chk_reset_tristate: assert property (@(posedge clk_sys) disable iff (1'b0)
        !rst_n |-> (port_pin_oe == '0 && port_pullup_en == '0))
        else $error("pins driven during reset");
    // latch read returns the stored value
    chk_latch_read: assert property (
        (setup & ~pwrite & hit_latch) |=> (prdata == {{(DATA_W-PORT_W){1'b0}}, $past(latch_q)}))
        else $error("latch read mismatch");
    // writes to the pin location store nothing
    chk_pin_readonly: assert property (
        (wr_done & hit_pin) |=> ($stable(latch_q) && $stable(dir_q)))
        else $error("pin location write changed state");
    // unmapped addresses answer with an error
    chk_decode_err: assert property (
        (setup & ~hit_any) |=> (pready && pslverr))
        else $error("unmapped address not flagged");
    // set alias only adds ones
    chk_set_bit: assert property (
        (wr_done & hit_lset) |=> (latch_q == ($past(latch_q) | $past(wbyte))))
        else $error("latch set touched other bits");
    // awake pins read back two clocks later
    chk_sync_delay: assert property (
        ((!power_down)[*3] ##0 ($past(rst_n) && $past(rst_n, 2))) |->
        (pif.sampled == $past(port_pin_i, 2)))
        else $error("synchroniser delay wrong");
    // power-down forces a fixed sampled level
    chk_sleep_level: assert property (
        power_down |-> (pif.sampled == {PORT_W{SLEEP_LEVEL}}))
        else $error("isolated input not fixed");

    // clear alias only removes ones
    chk_clear_bit: assert property (
        (wr_done & hit_lclr) |=> (latch_q == ($past(latch_q) & ~$past(wbyte))))
        else $error("latch clear touched other bits");

    // direction set alias only adds ones
    chk_dir_set: assert property (
        (wr_done & hit_dset) |=> (dir_q == ($past(dir_q) | $past(wbyte))))
        else $error("direction set touched other bits");

    // direction clear alias only removes ones
    chk_dir_clear: assert property (
        (wr_done & hit_dclr) |=> (dir_q == ($past(dir_q) & ~$past(wbyte))))
        else $error("direction clear touched other bits");

    // pin read returns the synchronised levels
    chk_pin_read: assert property (
        (setup & ~pwrite & hit_pin) |=> (prdata == {{(DATA_W-PORT_W){1'b0}}, $past(pif.sampled)}))
        else $error("pin level read mismatch");

    // direction register reads back what it stores
    chk_dir_read: assert property (
        (setup & ~pwrite & hit_dir) |=> (prdata == {{(DATA_W-PORT_W){1'b0}}, $past(dir_q)}))
        else $error("direction read mismatch");

    // a full latch write stores the low byte
    chk_latch_write: assert property (
        (wr_done & hit_latch) |=> (latch_q == $past(wbyte)))
        else $error("latch write lost");

    // input buffer cut one cycle after power-down starts
    chk_inbuf_follow: assert property (
        $past(rst_n) |-> (port_in_buf_en == ~$past(power_down)))
        else $error("input buffer enable wrong");

    // control write sets the global pull-up disable
    chk_ctrl_write: assert property (
        (wr_done & hit_ctrl) |=> (pu_dis_q == $past(pwdata[PU_DIS_BIT])))
        else $error("pull-up disable write lost");

    // ------------------------------------------------------------
    // scenario covers
    // ------------------------------------------------------------
    cov_latch_write: cover property (wr_done & hit_latch);
    cov_pin_read: cover property (done & ~pwrite & hit_pin);
    cov_pullup_on: cover property (pu_q != '0);
    cov_power_down: cover property (power_down ##1 !power_down);
    cov_alias_clear: cover property (wr_done & (hit_lclr | hit_dclr));
endmodule

// *** core/bpe_pkg.sv ***
// constants and register map of the eight-bit bidirectional port
package bpe_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int PORT_W = 8;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // ------------------------------------------------------------
    // register indices; byte address is index times four
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_PIN_LEVEL = 8'h19;
    localparam logic [7:0] IDX_DIRECTION = 8'h1A;
    localparam logic [7:0] IDX_OUT_LATCH = 8'h1B;
    localparam logic [7:0] IDX_SPEC_CTRL = 8'h1C;
    localparam logic [7:0] IDX_LATCH_SET = 8'h1D;
    localparam logic [7:0] IDX_LATCH_CLR = 8'h1E;
    localparam logic [7:0] IDX_DIR_SET = 8'h1F;
    localparam logic [7:0] IDX_DIR_CLR = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL = {2'h0, IDX_PIN_LEVEL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_DIRECTION = {2'h0, IDX_DIRECTION, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_OUT_LATCH = {2'h0, IDX_OUT_LATCH, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_SPEC_CTRL = {2'h0, IDX_SPEC_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_LATCH_SET = {2'h0, IDX_LATCH_SET, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_LATCH_CLR = {2'h0, IDX_LATCH_CLR, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_DIR_SET = {2'h0, IDX_DIR_SET, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_DIR_CLR = {2'h0, IDX_DIR_CLR, 2'h0};
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int PU_DIS_BIT = 2;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic RST_PU_DIS = 1'b0;
    localparam logic SLEEP_LEVEL = 1'b0;
    localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// *** core/bpe_pin_if.sv ***
// signals between the port core, its pin drive and its input sampler
`timescale 1ns/1ps
interface bpe_pin_if;
    import bpe_pkg::*;
    logic [PORT_W-1:0] latch;   // output latch bits
    logic [PORT_W-1:0] dir;     // direction bits, one is output
    logic pu_dis;               // global pull-up disable
    logic sleep;                // power-down in force
    logic [PORT_W-1:0] raw;     // unsynchronised pin levels
    logic [PORT_W-1:0] sampled; // synchronised pin levels
    logic [PORT_W-1:0] oe_d;    // next output enables
    logic [PORT_W-1:0] out_d;   // next driven levels
    logic [PORT_W-1:0] pu_d;    // next pull-up enables
    modport drv (input latch, dir, pu_dis, output oe_d, out_d, pu_d);
    modport smp (input raw, sleep, output sampled);
    modport core (output latch, dir, pu_dis, sleep, raw,
                  input sampled, oe_d, out_d, pu_d);
endinterface

// *** core/bpe_pin_drive.sv ***
// per-pin direction, level and pull-up decode
`timescale 1ns/1ps
module bpe_pin_drive
    import bpe_pkg::*;
(
    // pin control bundle
    bpe_pin_if.drv pif
);
    // ------------------------------------------------------------
    // one identical slice per pin
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_pin
            // direction one drives push-pull to the latch level
            assign pif.oe_d[gi] = pif.dir[gi];
            assign pif.out_d[gi] = pif.latch[gi];
            // pull-up only for an input with latch one, not disabled
            assign pif.pu_d[gi] = ~pif.dir[gi] & pif.latch[gi] & ~pif.pu_dis;
        end
    endgenerate
endmodule

// *** core/bpe_pin_sync.sv ***
// two-stage pin synchroniser with power-down input isolation
`timescale 1ns/1ps
module bpe_pin_sync
    import bpe_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // sampler bundle
    bpe_pin_if.smp pif
);
    logic [PORT_W-1:0] meta_q; // first stage, read by second only
    logic [PORT_W-1:0] sync_q; // second stage
    logic sleep_q;             // registered isolation state
    // ------------------------------------------------------------
    // synchroniser chain
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            sleep_q <= 1'b0;
        end else begin
            // raw pins enter the first stage with no gate in front
            meta_q <= pif.raw;
            sync_q <= meta_q;
            sleep_q <= pif.sleep;
        end
    end
    // input buffer cut in power-down: isolated inputs read a fixed level
    assign pif.sampled = (pif.sleep | sleep_q) ? {PORT_W{SLEEP_LEVEL}} : sync_q;
endmodule

// *** bench/bpe_pin_partner.sv ***
// board-side model of the eight package pins
`timescale 1ns/1ps
module bpe_pin_partner
    import bpe_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // pin controls from the port
    input wire logic [PORT_W-1:0] pin_o,
    input wire logic [PORT_W-1:0] pin_oe,
    input wire logic [PORT_W-1:0] pullup_en,
    // external drivers on the board
    input wire logic [PORT_W-1:0] ext_val,
    input wire logic [PORT_W-1:0] ext_en,
    // resolved pad level
    output logic [PORT_W-1:0] pin_level
);
    // ------------------------------------------------------------
    // wire resolution
    // ------------------------------------------------------------
    // a floating pad must not look stable, so it toggles every cycle
    logic [PORT_W-1:0] float_q = '0;
    always_ff @(posedge clk_sys) begin
        float_q <= ~float_q;
    end
    // port drive wins, then board drive, then pull-up, else floating
    assign pin_level = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
                     | (~pin_oe & ~ext_en & pullup_en)
                     | (~pin_oe & ~ext_en & ~pullup_en & float_q);
endmodule

// *** bench/bpe_port_tb.sv ***
// self-checking bench of the eight-bit bidirectional port
`timescale 1ns/1ps
module bpe_port_tb;
    import bpe_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, power_down, port_in_buf_en;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd_v;
    logic [PORT_W-1:0] pins, port_pin_o, port_pin_oe, port_pullup_en, ext_val, ext_en;
    logic [PORT_W-1:0] dir, lat, m;
    logic er_v, pu_dis;
    logic [ADDR_W-1:0] alias_addr [4] = '{ADDR_LATCH_SET, ADDR_LATCH_CLR,
                                          ADDR_DIR_SET, ADDR_DIR_CLR};
    int seed, err_total, cmp_count, cyc;
    bpe_port dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_down(power_down), .port_pin_i(pins), .port_pin_o(port_pin_o),
        .port_pin_oe(port_pin_oe), .port_pullup_en(port_pullup_en),
        .port_in_buf_en(port_in_buf_en));
    bpe_pin_partner board_u (.clk_sys(clk_sys), .pin_o(port_pin_o), .pin_oe(port_pin_oe),
        .pullup_en(port_pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_level(pins));
    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // whole run is under five hundred cycles; the ceiling leaves wide margin
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; waits an edge first so no strobe is set twice at once
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        // answer taken at the rising edge at which pready is seen high
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1);
        rd_v = prdata;
        er_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check(n, 1);
    endtask
    function automatic logic [7:0] exp_pull(input logic [7:0] d, l, input logic p);
        return ~d & l & {8{~p}};
    endfunction
    function automatic logic [7:0] exp_pin(input logic [7:0] d, l, e);
        return (d & l) | (~d & e);
    endfunction
    // read one register and compare its low byte, upper bytes zero
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd_v, {24'h0, exp});
        check(er_v, 1'b0);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'hC8152BCA;
        {rst_n, psel, penable, pwrite, power_down} = '0;
        paddr = '0;
        pwdata = '0;
        ext_val = '0;
        ext_en = '0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        check({port_pin_oe, port_pullup_en}, 16'h0);
        rd_chk(ADDR_OUT_LATCH, RST_LATCH);
        rd_chk(ADDR_DIRECTION, RST_DIRECTION);
        // random pin setups, the board drives every input pin
        repeat (16) begin
            dir = 8'($random(seed));
            lat = 8'($random(seed));
            pu_dis = 1'($random(seed));
            ext_val <= 8'($random(seed));
            ext_en <= ~dir;
            apb(1'b1, ADDR_SPEC_CTRL, {29'h0, pu_dis, 2'h0});
            apb(1'b1, ADDR_DIRECTION, {24'h0, dir});
            apb(1'b1, ADDR_OUT_LATCH, {24'h0, lat});
            repeat (4) @(posedge clk_sys);
            check(port_pin_oe, dir);
            check(port_pin_o & dir, lat & dir);
            check(port_pullup_en, exp_pull(dir, lat, pu_dis));
            rd_chk(ADDR_PIN_LEVEL, exp_pin(dir, lat, ext_val));
            rd_chk(ADDR_OUT_LATCH, lat);
            rd_chk(ADDR_DIRECTION, dir);
        end
        // single-bit and mask set/clear through the aliases
        for (int k = 0; k < 4; k++) begin
            m = (k[0]) ? 8'(8'h01 << k) : 8'($random(seed));
            apb(1'b1, alias_addr[k], {24'h0, m});
            case (k)
                0: lat = lat | m;
                1: lat = lat & ~m;
                2: dir = dir | m;
                default: dir = dir & ~m;
            endcase
            rd_chk(ADDR_OUT_LATCH, lat);
            rd_chk(ADDR_DIRECTION, dir);
        end
        // pin location ignores writes, unmapped place refused
        apb(1'b1, ADDR_PIN_LEVEL, 32'h0000_00A5);
        check(er_v, 1'b0);
        rd_chk(ADDR_OUT_LATCH, lat);
        apb(1'b0, 12'h0FC, 32'h0);
        check(rd_v, RDATA_ZERO);
        check(er_v, 1'b1);
        // power-down isolates inputs; outputs held steady meanwhile
        ext_en <= 8'hFF ^ dir;
        power_down <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check(port_in_buf_en, 1'b0);
        rd_chk(ADDR_PIN_LEVEL, {8{SLEEP_LEVEL}});
        power_down <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check(port_in_buf_en, 1'b1);
        rd_chk(ADDR_PIN_LEVEL, exp_pin(dir, lat, ext_val));
        // reset drops drive and pull-ups before any clock edge
        apb(1'b1, ADDR_SPEC_CTRL, 32'h0);
        apb(1'b1, ADDR_DIRECTION, 32'h0000_000F);
        apb(1'b1, ADDR_OUT_LATCH, 32'h0000_00F0);
        // board lets go, so only the pull-ups hold the inputs high
        ext_en <= 8'h00;
        repeat (3) @(posedge clk_sys);
        check({port_pin_oe, port_pullup_en}, 16'h0FF0);
        rd_chk(ADDR_PIN_LEVEL, 8'hF0);
        rst_n <= 1'b0;
        #1;
        check({port_pin_oe, port_pullup_en}, 16'h0);
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk(ADDR_OUT_LATCH, RST_LATCH);
        final_report();
    end
endmodule
